//--- fpe_error_response.sv
// The address map and the plain strobed port were left to the implementer.
package fpe_pkg;
   localparam int unsigned DW = 16;
   localparam int unsigned AW = 4;
   // ************************************************************
   // register offsets (byte addresses, word aligned)
   // ************************************************************
   localparam logic [3:0]  OFS_CTRL = 4'h0;
   localparam logic [3:0]  OFS_FLAG = 4'h4;
   localparam logic [3:0]  OFS_RSV  = 4'h8;
   localparam logic [3:0]  OFS_NMIV = 4'hc;
   // ************************************************************
   // fields
   // ************************************************************
   localparam int unsigned CTRL_SUPPLY_BIT = 0;
   localparam int unsigned CTRL_URST_BIT   = 1;
   localparam int unsigned CTRL_UIE_BIT    = 2;
   localparam int unsigned CTRL_CIE_BIT    = 3;
   localparam int unsigned CTRL_W          = 4;
   localparam int unsigned FLAG_CORR_BIT   = 0;
   localparam int unsigned FLAG_UNCORR_BIT = 1;
   localparam logic [3:0]  CTRL_RESET      = 4'h1;
   // ************************************************************
   // vector codes
   // ************************************************************
   localparam logic [15:0] RSV_NONE    = 16'h0000;
   localparam logic [15:0] RSV_UNCORR  = 16'h0010;
   localparam logic [15:0] NMIV_NONE   = 16'h0000;
   localparam logic [15:0] NMIV_UNCORR = 16'h0002;
   localparam logic [15:0] NMIV_CORR   = 16'h0004;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned PUC_LEN     = 4;
   localparam int unsigned SYS_CLK_HZ  = 25_000_000;
   // above this rate the uncorrectable-error reset may fire falsely
   localparam int unsigned MAX_SAFE_HZ = 12_000_000;
endpackage : fpe_pkg

`timescale 1ns/1ps
module fpe_error_response #(
   parameter int unsigned PUC_CYCLES = fpe_pkg::PUC_LEN
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   input  wire logic [fpe_pkg::AW-1:0] reg_addr,
   input  wire logic [fpe_pkg::DW-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [fpe_pkg::DW-1:0] reg_rdata,
   input  wire logic                   corr_err_det,
   input  wire logic                   uncorr_err_det,
   output logic                        power_up_clear,
   output logic                        nmi_req,
   output logic                        mem_supply_on
);
   // ************************************************************
   // control register
   // ************************************************************
   logic [fpe_pkg::CTRL_W-1:0] mem_ctrl_reg_first;
   logic                       uncorr_err_reset_en;
   logic                       uncorr_err_irq_en;
   logic                       corr_err_irq_en;
   logic                       uncorr_err_flag;
   logic                       corr_err_flag;
   logic [fpe_pkg::DW-1:0]     reset_source_vector;
   logic [fpe_pkg::DW-1:0]     system_nmi_vector;
   logic                       uncorr_ev;
   logic                       corr_ev;
   logic                       puc_trig;
   logic                       uncorr_irq;
   logic                       corr_irq;
   logic                       wr_ctrl;
   logic                       wr_flag;
   logic                       rd_rsv;
   logic                       rd_nmiv;

   assign uncorr_err_reset_en = mem_ctrl_reg_first[fpe_pkg::CTRL_URST_BIT];
   assign uncorr_err_irq_en   = mem_ctrl_reg_first[fpe_pkg::CTRL_UIE_BIT];
   assign corr_err_irq_en     = mem_ctrl_reg_first[fpe_pkg::CTRL_CIE_BIT];
   assign wr_ctrl = reg_wr && (reg_addr == fpe_pkg::OFS_CTRL);
   assign wr_flag = reg_wr && (reg_addr == fpe_pkg::OFS_FLAG);
   assign rd_rsv  = reg_rd && (reg_addr == fpe_pkg::OFS_RSV);
   assign rd_nmiv = reg_rd && (reg_addr == fpe_pkg::OFS_NMIV);

   // detector is dead with the supply off, and a clear in progress masks it
   assign uncorr_ev  = uncorr_err_det && mem_supply_on && !power_up_clear;
   assign corr_ev    = corr_err_det && mem_supply_on && !power_up_clear;
   assign puc_trig   = uncorr_ev && uncorr_err_reset_en;
   assign uncorr_irq = uncorr_ev && uncorr_err_irq_en;
   assign corr_irq   = corr_ev && corr_err_irq_en;

   // clear reloads control and loads the reset source vector; flags and the nmi vector are left alone
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_ctrl_reg_first <= fpe_pkg::CTRL_RESET;
      end else if (puc_trig) begin
         mem_ctrl_reg_first <= fpe_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         mem_ctrl_reg_first <= reg_wdata[fpe_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_supply_on <= fpe_pkg::CTRL_RESET[fpe_pkg::CTRL_SUPPLY_BIT];
      end else if (puc_trig) begin
         mem_supply_on <= fpe_pkg::CTRL_RESET[fpe_pkg::CTRL_SUPPLY_BIT];
      end else if (wr_ctrl) begin
         mem_supply_on <= reg_wdata[fpe_pkg::CTRL_SUPPLY_BIT];
      end
   end

   // ************************************************************
   // power-up clear request
   // ************************************************************
   fpe_pulse_stretch #(
      .LEN (PUC_CYCLES)
   ) u_puc (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .trig    (puc_trig),
      .busy    (power_up_clear)
   );

   // ************************************************************
   // error flags, write one to clear
   // ************************************************************
   fpe_sticky_flag u_uflag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_ev  (uncorr_ev),
      .clr_req (wr_flag && reg_wdata[fpe_pkg::FLAG_UNCORR_BIT]),
      .flag    (uncorr_err_flag)
   );

   fpe_sticky_flag u_cflag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_ev  (corr_ev),
      .clr_req (wr_flag && reg_wdata[fpe_pkg::FLAG_CORR_BIT]),
      .flag    (corr_err_flag)
   );

   // ************************************************************
   // vectors, cleared by reading, a new cause wins over the read, except a correctable one while the nmi vector holds uncorrectable
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reset_source_vector <= fpe_pkg::RSV_NONE;
      end else if (puc_trig) begin
         reset_source_vector <= fpe_pkg::RSV_UNCORR;
      end else if (rd_rsv) begin
         reset_source_vector <= fpe_pkg::RSV_NONE;
      end
   end

   // uncorrectable has priority; a correctable never hides it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         system_nmi_vector <= fpe_pkg::NMIV_NONE;
      end else if (uncorr_irq) begin
         system_nmi_vector <= fpe_pkg::NMIV_UNCORR;
      end else if (corr_irq && system_nmi_vector != fpe_pkg::NMIV_UNCORR) begin
         system_nmi_vector <= fpe_pkg::NMIV_CORR;
      end else if (rd_nmiv) begin
         system_nmi_vector <= fpe_pkg::NMIV_NONE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         nmi_req <= 1'b0;
      end else begin
         nmi_req <= uncorr_irq || corr_irq;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            fpe_pkg::OFS_CTRL: begin
               reg_rdata <= {{(fpe_pkg::DW-fpe_pkg::CTRL_W){1'b0}},
                             mem_ctrl_reg_first[fpe_pkg::CTRL_W-1:1], mem_supply_on};
            end
            fpe_pkg::OFS_FLAG: begin
               reg_rdata <= {{(fpe_pkg::DW-2){1'b0}}, uncorr_err_flag, corr_err_flag};
            end
            fpe_pkg::OFS_RSV: begin
               reg_rdata <= reset_source_vector;
            end
            fpe_pkg::OFS_NMIV: begin
               reg_rdata <= system_nmi_vector;
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   puc_start_a: assert property (uncorr_ev && uncorr_err_reset_en && !power_up_clear |=>
      power_up_clear[*4] ##1 !power_up_clear)
      else $error("clear pulse missing or wrong length");

   rsv_load_a: assert property (puc_trig |=> reset_source_vector == fpe_pkg::RSV_UNCORR)
      else $error("reset source not loaded");

   nmi_uncorr_a: assert property (uncorr_ev && uncorr_err_irq_en |=>
      nmi_req && system_nmi_vector == fpe_pkg::NMIV_UNCORR)
      else $error("uncorrectable nmi missing");

   nmi_corr_a: assert property (corr_ev && corr_err_irq_en && !uncorr_irq &&
      system_nmi_vector != fpe_pkg::NMIV_UNCORR |=>
      nmi_req && system_nmi_vector == fpe_pkg::NMIV_CORR)
      else $error("correctable nmi missing");

   flag_indep_a: assert property (wr_flag && reg_wdata[1:0] == 2'b01 && !corr_ev |=>
      !corr_err_flag && uncorr_err_flag == ($past(uncorr_err_flag) || $past(uncorr_ev)))
      else $error("flag clear not independent");

   rsv_idle_a: assert property (!$past(rst_n) |-> reset_source_vector == fpe_pkg::RSV_NONE)
      else $error("reset source not zero after reset");

   supply_off_a: assert property (wr_ctrl && !reg_wdata[0] && !puc_trig |=>
      !mem_supply_on ##1 !nmi_req)
      else $error("supply bit write not obeyed");

   flag_keep_a: assert property ($rose(power_up_clear) |-> uncorr_err_flag [*2])
      else $error("error flag lost across clear");

   nmi_no_en_a: assert property (!$past(uncorr_err_irq_en) && !$past(corr_err_irq_en) |->
      !nmi_req)
      else $error("nmi without enable");

   puc_cause_a: assert property ($rose(power_up_clear) |-> $past(uncorr_err_det) &&
      $past(uncorr_err_reset_en) && $past(mem_supply_on))
      else $error("clear without enabled uncorrectable error");

   puc_idle_a: assert property (power_up_clear |=> !nmi_req)
      else $error("error taken during clear pulse");

   rsv_cause_a: assert property ($changed(reset_source_vector) &&
      reset_source_vector == fpe_pkg::RSV_UNCORR |-> $past(puc_trig))
      else $error("reset source set without clear");

   rsv_clear_a: assert property (rd_rsv && !puc_trig |=>
      reset_source_vector == fpe_pkg::RSV_NONE)
      else $error("reset source not cleared by read");

   nmiv_keep_a: assert property (system_nmi_vector == fpe_pkg::NMIV_UNCORR &&
      !rd_nmiv |=> system_nmi_vector == fpe_pkg::NMIV_UNCORR)
      else $error("uncorrectable vector overwritten");

   uflag_clr_a: assert property (wr_flag && reg_wdata[1:0] == 2'b10 && !uncorr_ev |=>
      !uncorr_err_flag && corr_err_flag == ($past(corr_err_flag) || $past(corr_ev)))
      else $error("uncorrectable flag clear not independent");

   uflag_set_a: assert property (uncorr_ev |=> uncorr_err_flag)
      else $error("uncorrectable flag not set");

   cflag_set_a: assert property (corr_ev |=> corr_err_flag)
      else $error("correctable flag not set");

   // with the regulator off the detector output is meaningless
   supply_mask_a: assert property (!mem_supply_on && !power_up_clear |=>
      !nmi_req && !power_up_clear)
      else $error("error taken with supply off");

   supply_mirror_a: assert property (mem_supply_on ==
      mem_ctrl_reg_first[fpe_pkg::CTRL_SUPPLY_BIT])
      else $error("supply bit and control copy differ");

   // ************************************************************
   // scenario covers
   // ************************************************************
   puc_cov: cover property (puc_trig ##1 power_up_clear);
   nmi_cov: cover property (corr_irq ##1 nmi_req);
   both_cov: cover property (uncorr_irq && corr_irq);
   rd_cov: cover property (rd_rsv && reset_source_vector == fpe_pkg::RSV_UNCORR);
   supply_cov: cover property (!mem_supply_on && uncorr_err_det);
endmodule : fpe_error_response

//--- fpe_error_response_tb.sv
`timescale 1ns/1ps
// ************************************************************
// bench with integer reference model
// ************************************************************
module fpe_error_response_tb;
   logic                   sys_clk        = 1'b0;
   logic                   rst_n          = 1'b0;
   logic [fpe_pkg::AW-1:0] reg_addr       = 4'h0;
   logic [fpe_pkg::DW-1:0] reg_wdata      = 16'h0000;
   logic                   reg_wr         = 1'b0;
   logic                   reg_rd         = 1'b0;
   logic                   corr_err_det   = 1'b0;
   logic                   uncorr_err_det = 1'b0;
   logic [fpe_pkg::DW-1:0] reg_rdata;
   logic                   power_up_clear;
   logic                   nmi_req;
   logic                   mem_supply_on;
   logic [3:0]             m_ctrl;
   logic [15:0]            m_flag, m_rsv, m_nmiv, rv;
   int                     n_errors = 0;
   int                     checked  = 0;
   int                     cycles   = 0;
   int                     e_nmi    = 0;
   int                     e_puc    = 0;

   fpe_error_response #(.PUC_CYCLES(fpe_pkg::PUC_LEN)) fpe_error_response_i (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .corr_err_det  (corr_err_det),
      .uncorr_err_det(uncorr_err_det),
      .power_up_clear(power_up_clear),
      .nmi_req       (nmi_req),
      .mem_supply_on (mem_supply_on)
   );
   fpe_reset_ctl_model fpe_reset_ctl_model_i (
      .sys_clk       (sys_clk),
      .power_up_clear(power_up_clear),
      .nmi_req       (nmi_req)
   );

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // generous ceiling: the whole run needs well under two thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end

   task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg
   task automatic chk_cnt(input string nm, input int e, input int g);
      checked++;
      if (g != e) begin
         n_errors++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
   // one error pulse, then let any clear pulse run out
   task automatic err(input int kind);
      @(posedge sys_clk);
      // only genuine errors are injected, so no false detect needs filtering
      if (kind == 1) corr_err_det <= 1'b1;
      else uncorr_err_det <= 1'b1;
      @(posedge sys_clk);
      corr_err_det   <= 1'b0;
      uncorr_err_det <= 1'b0;
      if (m_ctrl[0] && kind == 1) begin
         m_flag[0] = 1'b1;
         if (m_ctrl[3]) begin
            e_nmi++;
            if (m_nmiv != 16'h0002) m_nmiv = 16'h0004;
         end
      end else if (m_ctrl[0]) begin
         m_flag[1] = 1'b1;
         if (m_ctrl[2]) begin
            e_nmi++;
            m_nmiv = 16'h0002;
         end
         if (m_ctrl[1]) begin
            e_puc++;
            m_rsv  = 16'h0010;
            m_ctrl = 4'h1;
         end
      end
      repeat (8) @(posedge sys_clk);
   endtask : err
   task automatic check_all;
      rd(fpe_pkg::OFS_FLAG, rv);
      chk_reg("flags", m_flag, rv);
      rd(fpe_pkg::OFS_RSV, rv);
      chk_reg("reset_source_vector", m_rsv, rv);
      rd(fpe_pkg::OFS_NMIV, rv);
      chk_reg("system_nmi_vector", m_nmiv, rv);
      rd(fpe_pkg::OFS_CTRL, rv);
      chk_reg("mem_ctrl_reg_first", {12'h000, m_ctrl}, rv);
      chk_cnt("nmi pulses", e_nmi, fpe_reset_ctl_model_i.n_nmi);
      chk_cnt("clear pulses", e_puc, fpe_reset_ctl_model_i.n_puc);
      if (e_puc > 0) begin
         chk_cnt("clear length", fpe_pkg::PUC_LEN, fpe_reset_ctl_model_i.puc_len);
      end
      m_rsv  = 16'h0000;
      m_nmiv = 16'h0000;
   endtask : check_all
   task automatic results;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      void'($urandom(32'hfecb));
      m_ctrl = 4'h1;
      m_flag = 16'h0000;
      m_rsv  = 16'h0000;
      m_nmiv = 16'h0000;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(4'h2, rv);
      chk_reg("unmapped read", 16'h0000, rv);
      wr(4'h2, 16'hffff);
      check_all();
      // enables already clear from reset; this write turns only the supply off
      wr(fpe_pkg::OFS_CTRL, 16'h0000);
      m_ctrl = 4'h0;
      @(negedge sys_clk);
      chk_reg("mem_supply_on", 16'h0000, {15'h0000, mem_supply_on});
      err(2);
      err(1);
      check_all();
      wr(fpe_pkg::OFS_CTRL, 16'h0001);
      m_ctrl = 4'h1;
      @(negedge sys_clk);
      chk_reg("mem_supply_on", 16'h0001, {15'h0000, mem_supply_on});
      err(1);
      err(2);
      check_all();
      wr(fpe_pkg::OFS_FLAG, 16'h0001);
      m_flag = 16'h0002;
      rd(fpe_pkg::OFS_FLAG, rv);
      chk_reg("flags", m_flag, rv);
      wr(fpe_pkg::OFS_FLAG, 16'h0002);
      rd(fpe_pkg::OFS_FLAG, rv);
      chk_reg("flags", 16'h0000, rv);
      m_flag = 16'h0000;
      for (int i = 0; i < 40; i++) begin
         m_ctrl = {3'($urandom % 8), 1'b1};
         wr(fpe_pkg::OFS_CTRL, {12'h000, m_ctrl});
         err(int'($urandom_range(1, 2)));
         if ($urandom % 2) err(int'($urandom_range(1, 2)));
         check_all();
         // flags cleared after the access, as after a wake-up
         wr(fpe_pkg::OFS_FLAG, 16'h0003);
         m_flag = 16'h0000;
      end
      results();
   end
endmodule : fpe_error_response_tb

//--- fpe_pulse_stretch.sv
`timescale 1ns/1ps
// ************************************************************
// fixed-length pulse from a one-cycle trigger
// ************************************************************
module fpe_pulse_stretch #(
   parameter int unsigned LEN = 4
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic trig,
   output logic      busy
);
   localparam int unsigned CW = (LEN > 1) ? $clog2(LEN) : 1;
   logic [CW-1:0] cnt;

   // retrigger while busy is ignored, the pulse length stays fixed
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt  <= '0;
      end else if (!busy && trig) begin
         busy <= 1'b1;
         cnt  <= CW'(LEN - 1);
      end else if (busy) begin
         if (cnt == '0) begin
            busy <= 1'b0;
         end else begin
            cnt <= cnt - CW'(1);
         end
      end
   end
endmodule : fpe_pulse_stretch

//--- fpe_reset_ctl_model.sv
`timescale 1ns/1ps
// ************************************************************
// far side: system reset and nmi controller
// ************************************************************
module fpe_reset_ctl_model (
   input wire logic sys_clk,
   input wire logic power_up_clear,
   input wire logic nmi_req
);
   int n_nmi   = 0;
   int n_puc   = 0;
   int puc_len = 0;
   int run     = 0;
   // a clear is counted once it ends, so its length is known
   always @(posedge sys_clk) begin
      if (nmi_req === 1'b1) n_nmi++;
      if (power_up_clear === 1'b1) run++;
      else if (run > 0) begin
         puc_len = run;
         n_puc++;
         run = 0;
      end
   end
endmodule : fpe_reset_ctl_model

//--- fpe_sticky_flag.sv
`timescale 1ns/1ps
// ************************************************************
// sticky flag, set wins over clear
// ************************************************************
module fpe_sticky_flag (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic set_ev,
   input  wire logic clr_req,
   output logic      flag
);
   // a new event in the clearing cycle must not be lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (set_ev) begin
         flag <= 1'b1;
      end else if (clr_req) begin
         flag <= 1'b0;
      end
   end
endmodule : fpe_sticky_flag
